//--- common/ddc_pkg.sv
// Constants for the datapath control register bank.
// Assumes an APB master on a single 125 MHz clock domain.
// Operation
// R1 - Bit 15 set turns on quadrature offset correction, clear turns it off.
// R2 - Bit 13 set turns on quadrature phase and gain correction, clear bypasses it.
// R3 - Bits 11:8 choose interpolation 0000=1x 0001=2x 0010=4x 0100=8x 1000=16x, reset 0100.
// R4 - Bit 7 enables the input sample FIFO, reset one.
// R5 - With the FIFO off the outside source must keep sample and data clocks aligned.
// R6 - Bit 4 set drives the fault pin, clear floats it, reset one.
// R7 - Bit 3 picks fault polarity, zero active low and one active high, reset one.
// R8 - Bit 2 set resynchronises the clock divider from the chosen sync source, reset one.
// R9 - Bit 1 set routes samples through the inverse-sinc filter, reset zero.
// R10 - Bits 14, 12, 6, 5 and 0 are factory bits that reset to zero with no user function.
// R11 - The control register sits at address 0x00 and resets to 0x049C.
// R12 - Software keeps factory bits at their defaults when it writes.
// R13 - A written value reaches the datapath right after the write completes.
package ddc_pkg;
    // =========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [15:0] CTRL_RESET = 16'h049c;
    localparam logic [15:0] CTRL_RESERVED_MASK = 16'h5061;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // =========================================================
    // Control fields
    localparam int BIT_OFFSET_ENA = 15;
    localparam int BIT_CORR_ENA = 13;
    localparam int INTERP_LSB = 8;
    localparam int INTERP_MSB = 11;
    localparam int BIT_FIFO_ENA = 7;
    localparam int BIT_FAULT_DRIVE = 4;
    localparam int BIT_FAULT_POL = 3;
    localparam int BIT_DIV_SYNC = 2;
    localparam int BIT_INVSINC_ENA = 1;
    // =========================================================
    // Interpolation codes
    localparam logic [3:0] INTERP_1X = 4'h0;
    localparam logic [3:0] INTERP_2X = 4'h1;
    localparam logic [3:0] INTERP_4X = 4'h2;
    localparam logic [3:0] INTERP_8X = 4'h4;
    localparam logic [3:0] INTERP_16X = 4'h8;
    // =========================================================
    // Interrupt status bits
    localparam int IRQ_WRITE = 0;
    localparam int IRQ_BAD_INTERP = 1;
    localparam int IRQ_SYNC_DONE = 2;

    // Legal interpolation code check, shared by bank and assertions
    function automatic logic interp_legal(input logic [3:0] code);
        return (code == INTERP_1X) || (code == INTERP_2X) || (code == INTERP_4X) ||
               (code == INTERP_8X) || (code == INTERP_16X);
    endfunction : interp_legal
endpackage : ddc_pkg

//--- logic/ddc_ctrl_bank.sv
// Datapath control register bank with APB slave and interrupt logic.
// Assumes a single 125 MHz clock and an APB master on the same clock.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module ddc_ctrl_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Datapath controls
    output logic offsetCorrEna,
    output logic gainPhaseCorrEna,
    output logic [3:0] interpRatio,
    output logic fifoEna,
    output logic divSyncEna,
    output logic invSincEna,
    // Sync and fault inputs from other domains
    input wire logic syncSourcePulse,
    input wire logic faultEvent,
    // Fault pin
    output logic faultPinOut,
    output logic faultPinOen,
    // Interrupt
    output logic irq
);
    // =========================================================
    // State
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_DONE} ddc_apb_state_t;

    ddc_apb_state_t state_q;
    ddc_apb_state_t state_d;
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [2:0] irqStatus_q;
    logic [2:0] irqStatus_d;
    logic [2:0] irqMask_q;
    logic [2:0] irqMask_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic irq_q;
    logic irq_d;
    logic syncPrev_q;
    logic syncPrev_d;
    logic faultSync;
    logic syncLevel;
    logic syncEdge;
    logic wrCtrl;
    logic wrStatus;
    logic wrMask;
    logic accessNow;
    logic addrHit;
    logic [2:0] irqEvents;
    logic [15:0] wrData16;

    // =========================================================
    // Crossings
    ddc_sync2 u_sync_fault (
        .clk(clk),
        .rstn(rstn),
        .async(faultEvent),
        .sync(faultSync)
    );

    ddc_sync2 u_sync_src (
        .clk(clk),
        .rstn(rstn),
        .async(syncSourcePulse),
        .sync(syncLevel)
    );

    // =========================================================
    // APB decode
    always_comb begin
        // Writes land at the edge where the master sees pready, never earlier
        accessNow = psel && penable && (state_q == ST_DONE);
        addrHit = (paddr == ddc_pkg::ADDR_CTRL) || (paddr == ddc_pkg::ADDR_IRQ_STATUS) ||
                  (paddr == ddc_pkg::ADDR_IRQ_MASK);
        // R11 control register at address 0x00
        wrCtrl = accessNow && pwrite && (paddr == ddc_pkg::ADDR_CTRL);
        wrStatus = accessNow && pwrite && (paddr == ddc_pkg::ADDR_IRQ_STATUS) && pstrb[0];
        wrMask = accessNow && pwrite && (paddr == ddc_pkg::ADDR_IRQ_MASK) && pstrb[0];
        wrData16[7:0] = pstrb[0] ? pwdata[7:0] : ctrl_q[7:0];
        wrData16[15:8] = pstrb[1] ? pwdata[15:8] : ctrl_q[15:8];
    end

    always_comb begin
        state_d = state_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        case (state_q)
            ST_IDLE: begin
                if (psel && !penable) begin
                    state_d = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                // One wait state: answer registered for the next edge
                if (psel && penable) begin
                    state_d = ST_DONE;
                    pready_d = 1'b1;
                    pslverr_d = !addrHit;
                    prdata_d = 32'h0000_0000;
                    if (!pwrite) begin
                        case (paddr)
                            ddc_pkg::ADDR_CTRL: prdata_d = {16'h0000, ctrl_q};
                            ddc_pkg::ADDR_IRQ_STATUS: prdata_d = {29'h0, irqStatus_q};
                            ddc_pkg::ADDR_IRQ_MASK: prdata_d = {29'h0, irqMask_q};
                            default: prdata_d = 32'h0000_0000;
                        endcase
                    end
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // =========================================================
    // Control register
    always_comb begin
        ctrl_d = ctrl_q;
        // R13 new value applies from the edge that completes the write
        if (wrCtrl) begin
            // R10 factory bits keep reset value, no user function
            ctrl_d = wrData16 & ~ddc_pkg::CTRL_RESERVED_MASK;
        end
    end

    // =========================================================
    // Interrupts
    always_comb begin
        syncPrev_d = syncLevel;
        syncEdge = syncLevel && !syncPrev_q;
        irqEvents = 3'h0;
        irqEvents[ddc_pkg::IRQ_WRITE] = faultSync;
        // R3 unlisted interpolation codes are flagged to software
        irqEvents[ddc_pkg::IRQ_BAD_INTERP] = !ddc_pkg::interp_legal(ctrl_q[11:8]);
        // R8 divider resync from the selected source when enabled
        irqEvents[ddc_pkg::IRQ_SYNC_DONE] = syncEdge && ctrl_q[ddc_pkg::BIT_DIV_SYNC];
        irqStatus_d = irqStatus_q;
        if (wrStatus) begin
            irqStatus_d = irqStatus_q & ~pwdata[2:0];
        end
        // Set wins over a clear in the same cycle
        irqStatus_d = irqStatus_d | irqEvents;
        irqMask_d = wrMask ? pwdata[2:0] : irqMask_q;
        irq_d = |(irqStatus_d & irqMask_d);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            // R11 reset value 0x049C
            ctrl_q <= ddc_pkg::CTRL_RESET;
            irqStatus_q <= ddc_pkg::IRQ_RESET;
            irqMask_q <= ddc_pkg::IRQ_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
            syncPrev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            irqStatus_q <= irqStatus_d;
            irqMask_q <= irqMask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
            syncPrev_q <= syncPrev_d;
        end
    end

    // =========================================================
    // Outputs
    ddc_fault_pin u_fault_pin (
        .clk(clk),
        .rstn(rstn),
        .faultActive(faultSync),
        .driveEna(ctrl_q[ddc_pkg::BIT_FAULT_DRIVE]),
        .polHigh(ctrl_q[ddc_pkg::BIT_FAULT_POL]),
        .faultPinOut(faultPinOut),
        .faultPinOen(faultPinOen)
    );

    // Datapath enables come straight from the register flops
    // R1 offset correction enable
    assign offsetCorrEna = ctrl_q[ddc_pkg::BIT_OFFSET_ENA];
    // R2 gain and phase correction enable
    assign gainPhaseCorrEna = ctrl_q[ddc_pkg::BIT_CORR_ENA];
    // R3 interpolation ratio code
    assign interpRatio = ctrl_q[ddc_pkg::INTERP_MSB:ddc_pkg::INTERP_LSB];
    // R4 input FIFO enable; with it off the R5 clock alignment is on the source
    assign fifoEna = ctrl_q[ddc_pkg::BIT_FIFO_ENA];
    // R8 divider sync enable
    assign divSyncEna = ctrl_q[ddc_pkg::BIT_DIV_SYNC];
    // R9 inverse-sinc filter enable
    assign invSincEna = ctrl_q[ddc_pkg::BIT_INVSINC_ENA];
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    // =========================================================
    // Checks
    sequence s_ctrl_write;
        psel && penable && pwrite && pready && (paddr == ddc_pkg::ADDR_CTRL) && (&pstrb[1:0]);
    endsequence

    sequence s_ctrl_read;
        psel && penable && !pwrite && pready && (paddr == ddc_pkg::ADDR_CTRL);
    endsequence

    sequence s_apb_setup;
        (psel && !penable) ##1 (psel && penable);
    endsequence

    chk_reset_value: assert property (@(posedge clk) // R11
        $rose(rstn) |-> ctrl_q == ddc_pkg::CTRL_RESET)
        else $error("control register reset value wrong");
    chk_write_applies: assert property (@(posedge clk) disable iff (!rstn) // R13
        s_ctrl_write |=> offsetCorrEna == $past(pwdata[ddc_pkg::BIT_OFFSET_ENA]))
        else $error("offset enable not updated after write");
    chk_offset_ena: assert property (@(posedge clk) disable iff (!rstn) // R1
        !wrCtrl |=> $stable(offsetCorrEna))
        else $error("offset enable changed without a write");
    chk_corr_ena: assert property (@(posedge clk) disable iff (!rstn) // R2
        s_ctrl_write |=> gainPhaseCorrEna == $past(pwdata[ddc_pkg::BIT_CORR_ENA]))
        else $error("gain phase enable not updated");
    chk_interp_field: assert property (@(posedge clk) disable iff (!rstn) // R3
        s_ctrl_write |=> interpRatio == $past(pwdata[ddc_pkg::INTERP_MSB:ddc_pkg::INTERP_LSB]))
        else $error("interpolation field not updated");
    chk_fifo_ena: assert property (@(posedge clk) disable iff (!rstn) // R4
        s_ctrl_write |=> fifoEna == $past(pwdata[ddc_pkg::BIT_FIFO_ENA]))
        else $error("fifo enable not updated");
    chk_fault_float: assert property (@(posedge clk) disable iff (!rstn) // R6
        !ctrl_q[ddc_pkg::BIT_FAULT_DRIVE] ##1 !ctrl_q[ddc_pkg::BIT_FAULT_DRIVE] |-> faultPinOen)
        else $error("fault pin driven while disabled");
    chk_fault_drive: assert property (@(posedge clk) disable iff (!rstn) // R6
        ctrl_q[ddc_pkg::BIT_FAULT_DRIVE] |=> !faultPinOen)
        else $error("fault pin not driven while enabled");
    chk_fault_pol: assert property (@(posedge clk) disable iff (!rstn) // R7
        faultPinOut == ($past(ctrl_q[ddc_pkg::BIT_FAULT_POL]) ~^ $past(faultSync)))
        else $error("fault pin polarity wrong");
    chk_sync_ena: assert property (@(posedge clk) disable iff (!rstn) // R8
        s_ctrl_write |=> divSyncEna == $past(pwdata[ddc_pkg::BIT_DIV_SYNC]))
        else $error("divider sync enable not updated");
    chk_invsinc: assert property (@(posedge clk) disable iff (!rstn) // R9
        s_ctrl_write |=> invSincEna == $past(pwdata[ddc_pkg::BIT_INVSINC_ENA]))
        else $error("inverse sinc enable not updated");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rstn) // R10
        (ctrl_q & ddc_pkg::CTRL_RESERVED_MASK) == 16'h0000)
        else $error("factory bit set");
    chk_ctrl_hold: assert property (@(posedge clk) disable iff (!rstn) // R13
        !wrCtrl |=> $stable(ctrl_q))
        else $error("control register changed without a write");
    chk_read_ctrl: assert property (@(posedge clk) disable iff (!rstn) // R11
        s_ctrl_read |-> prdata == {16'h0000, ctrl_q})
        else $error("control register read data wrong");

    // =========================================================
    // Bus and interrupt checks
    chk_access_answer: assert property (@(posedge clk) disable iff (!rstn)
        s_apb_setup |=> pready)
        else $error("access phase not answered after one wait state");
    chk_pready_pulse: assert property (@(posedge clk) disable iff (!rstn)
        pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_slverr_pair: assert property (@(posedge clk) disable iff (!rstn)
        pslverr |-> pready)
        else $error("pslverr without pready");
    chk_bad_interp: assert property (@(posedge clk) disable iff (!rstn) // R3
        !ddc_pkg::interp_legal(interpRatio) |=> irqStatus_q[ddc_pkg::IRQ_BAD_INTERP])
        else $error("unlisted interpolation code not flagged");
    chk_sync_event: assert property (@(posedge clk) disable iff (!rstn) // R8
        syncEdge && divSyncEna |=> irqStatus_q[ddc_pkg::IRQ_SYNC_DONE])
        else $error("divider sync event not flagged");
    chk_status_sticky: assert property (@(posedge clk) disable iff (!rstn)
        !wrStatus |=> (irqStatus_q & $past(irqStatus_q)) == $past(irqStatus_q))
        else $error("status bit lost without a clear");
    chk_mask_write: assert property (@(posedge clk) disable iff (!rstn)
        wrMask |=> irqMask_q == $past(pwdata[2:0]))
        else $error("mask register not updated");
    chk_irq_level: assert property (@(posedge clk) disable iff (!rstn)
        irq == |(irqStatus_q & irqMask_q))
        else $error("interrupt level does not follow status and mask");
endmodule : ddc_ctrl_bank

//--- logic/ddc_fault_pin.sv
// Fault pin driver: polarity and drive enable from the control register.
// Assumes the fault level is already synchronous to clk.
`timescale 1ns/1ns
module ddc_fault_pin (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic faultActive,
    input wire logic driveEna,
    input wire logic polHigh,
    // Pin
    output logic faultPinOut,
    output logic faultPinOen
);
    logic out_q;
    logic out_d;
    logic oen_q;
    logic oen_d;

    always_comb begin
        // R7 polarity select
        out_d = polHigh ? faultActive : ~faultActive;
        // R6 drive or float, enable active low
        oen_d = ~driveEna;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_q <= 1'b0;
            oen_q <= 1'b1;
        end else begin
            out_q <= out_d;
            oen_q <= oen_d;
        end
    end

    assign faultPinOut = out_q;
    assign faultPinOen = oen_q;
endmodule : ddc_fault_pin

//--- logic/ddc_sync2.sv
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes clk is the register bank clock.
`timescale 1ns/1ns
module ddc_sync2 (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Level
    input wire logic async,
    output logic sync
);
    logic stage1_q;
    logic stage2_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= async;
            stage2_q <= stage1_q;
        end
    end

    assign sync = stage2_q;
endmodule : ddc_sync2

//--- verification/tb.sv
// Self-checking bench for the datapath control register bank.
// Assumes the bank answers APB with one wait state and drives the datapath from its flops.
`timescale 1ns/1ns
module tb;
    // =========================================================
    // Clock, reset and ports
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic offsetCorrEna, gainPhaseCorrEna, fifoEna, divSyncEna, invSincEna;
    logic [3:0] interpRatio;
    logic syncSourcePulse = 1'b0;
    logic faultEvent = 1'b0;
    logic faultPinOut, faultPinOen, irq;
    int miscompares = 0;
    int numChecks = 0;
    logic [31:0] rd;
    logic err;
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};

    always #4 clk = ~clk;

    ddc_ctrl_bank dut_u (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .offsetCorrEna(offsetCorrEna), .gainPhaseCorrEna(gainPhaseCorrEna),
        .interpRatio(interpRatio), .fifoEna(fifoEna), .divSyncEna(divSyncEna),
        .invSincEna(invSincEna), .syncSourcePulse(syncSourcePulse), .faultEvent(faultEvent),
        .faultPinOut(faultPinOut), .faultPinOen(faultPinOen), .irq(irq)
    );

    // =========================================================
    // Closing report
    task automatic results;
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // =========================================================
    // APB master: setup, access held until pready, then release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            miscompares++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the completing edge settle before anyone looks at outputs
        @(negedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000, 4'h0);
        chk(name, rd, exp);
    endtask : rdchk

    task automatic settle;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // =========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("outputs", {offsetCorrEna, gainPhaseCorrEna, fifoEna}, 32'h1);
        chk("interp rst", interpRatio, 4'h4);
        chk("ctl", {divSyncEna, invSincEna, faultPinOen, irq}, 32'h8);
        rdchk("ctrl reset", 8'h00, 32'h0000049c);
        rdchk("status reset", 8'h04, 32'h0);
        rdchk("mask reset", 8'h08, 32'h0);
        // Factory bits read back zero; enables follow at once
        wr(8'h00, 32'h0000ffff);
        chk("en", {offsetCorrEna, gainPhaseCorrEna, fifoEna, invSincEna}, 32'hf);
        rdchk("ctrl all", 8'h00, 32'h0000af9e);
        // FIFO off is safe here: the bench runs no sample clocks to misalign
        wr(8'h00, 32'h00000000);
        chk("dis", {offsetCorrEna, gainPhaseCorrEna, fifoEna, invSincEna}, 32'h0);
        settle();
        chk("oen off", faultPinOen, 1'b1);
        chk("dsync off", divSyncEna, 1'b0);
        apb(1'b1, 8'h00, 32'h0000ffff, 4'h1);
        rdchk("low lane", 8'h00, 32'h0000009e);
        wr(8'h04, 32'h7);
        // Every legal interpolation code, none flags an error
        foreach (codes[i]) begin
            wr(8'h00, {20'h0, codes[i], 8'h9c});
            chk("interp", interpRatio, codes[i]);
        end
        rdchk("no bad code", 8'h04, 32'h0);
        wr(8'h00, 32'h00000f9c);
        rdchk("bad code", 8'h04, 32'h2);
        wr(8'h08, 32'h2);
        chk("irq on", irq, 1'b1);
        wr(8'h00, 32'h0000049c);
        wr(8'h04, 32'h2);
        chk("irq clr", irq, 1'b0);
        rdchk("status clr", 8'h04, 32'h0);
        // Fault pin polarity and drive
        @(posedge clk) faultEvent <= 1'b1;
        settle();
        chk("pin hi pol", {faultPinOut, faultPinOen}, 32'h2);
        wr(8'h00, 32'h00000494);
        settle();
        chk("pin lo pol", faultPinOut, 1'b0);
        rdchk("fault st", 8'h04, 32'h1);
        wr(8'h08, 32'h1);
        chk("irq fault", irq, 1'b1);
        // Set wins while the fault is still present
        wr(8'h04, 32'h1);
        rdchk("set wins", 8'h04, 32'h1);
        @(posedge clk) faultEvent <= 1'b0;
        settle();
        chk("pin idle", faultPinOut, 1'b1);
        wr(8'h04, 32'h1);
        chk("irq off", irq, 1'b0);
        wr(8'h00, 32'h0000048c);
        settle();
        chk("pin float", faultPinOen, 1'b1);
        // Divider sync flagged in the status register only when enabled
        wr(8'h08, 32'h4);
        wr(8'h00, 32'h00000498);
        @(posedge clk) syncSourcePulse <= 1'b1;
        settle();
        rdchk("sync off", 8'h04, 32'h0);
        @(posedge clk) syncSourcePulse <= 1'b0;
        wr(8'h00, 32'h0000049c);
        @(posedge clk) syncSourcePulse <= 1'b1;
        settle();
        rdchk("sync on", 8'h04, 32'h4);
        chk("irq sync", irq, 1'b1);
        @(posedge clk) syncSourcePulse <= 1'b0;
        wr(8'h04, 32'h4);
        // Unmapped places answer with an error and change nothing
        apb(1'b1, 8'h10, 32'h0000ffff, 4'hf);
        chk("wr err", err, 1'b1);
        apb(1'b0, 8'h0c, 32'h0, 4'h0);
        chk("rd err", err, 1'b1);
        chk("rd data", rd, 32'h0);
        rdchk("ctrl kept", 8'h00, 32'h0000049c);
        results();
    end
endmodule : tb
